// file: logic/uprc_pkg.sv
// Constants and types for the reference-clock start-up controller.
// Assumes a single 20 MHz system clock; all pins are sampled by it.
package uprc_pkg;
	// System clock period and derived counts
	localparam int SYS_PERIOD_NS = 50;
	localparam int RST_MIN_NS = 1000;
	localparam int RST_MIN_CYC_I = (RST_MIN_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
	localparam logic [7:0] RST_MIN_CYC = RST_MIN_CYC_I[7:0];
	// Lock monitor: stable edges before lock, cycles without an edge before loss
	localparam logic [7:0] LOCK_EDGES = 8'h10;
	localparam logic [7:0] REF_TIMEOUT_CYC = 8'h20;
	// Clock-out divider half periods, locked and at PLL minimum
	localparam logic [7:0] INTERFACE_CLOCK_OUT_LOCK_DIV = 8'h01;
	localparam logic [7:0] INTERFACE_CLOCK_OUT_MIN_DIV = 8'h08;
	// Data bus idle pattern
	localparam logic [7:0] ULPI_IDLE = 8'h00;

	typedef enum logic [2:0] {
		UPRC_RESET,
		UPRC_STRAP,
		UPRC_WAIT_LOCK,
		UPRC_WAIT_STP,
		UPRC_RUN,
		UPRC_LOW_POWER
	} uprc_state_t;
endpackage

// file: logic/uprc_lock_mon.sv
// Reference clock rising-edge finder and lock monitor.
// Assumes the reference pin is asynchronous to i_sys_clk.
`timescale 1ns/1ps
module uprc_lock_mon #(
	parameter logic [7:0] LOCK_EDGES = uprc_pkg::LOCK_EDGES,
	parameter logic [7:0] TIMEOUT = uprc_pkg::REF_TIMEOUT_CYC
) (
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	input wire logic i_hold,
	input wire logic i_reference_clock_in,
	output logic o_locked,
	output logic o_ref_edge
);
	logic ref_s1;
	logic ref_s2;
	logic ref_s3;
	logic [7:0] edge_cnt;
	logic [7:0] gap_cnt;
	wire rise = ref_s2 & ~ref_s3;
	wire gap_out = (gap_cnt >= TIMEOUT);
	wire edge_full = (edge_cnt >= LOCK_EDGES);

	always_ff @(posedge i_sys_clk) begin
		ref_s1 <= i_reference_clock_in;
		ref_s2 <= ref_s1;
		ref_s3 <= ref_s2;
	end

	// Only rising edges count; falling edges are ignored
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst || i_hold) begin
			edge_cnt <= 8'h00;
			gap_cnt <= 8'h00;
			o_locked <= 1'b0;
			o_ref_edge <= 1'b0;
		end else begin
			o_ref_edge <= rise;
			if (rise) begin
				gap_cnt <= 8'h00;
				if (!edge_full) begin
					edge_cnt <= edge_cnt + 8'h01;
				end
			end else if (!gap_out) begin
				gap_cnt <= gap_cnt + 8'h01;
			end
			if (gap_out) begin
				edge_cnt <= 8'h00;
				o_locked <= 1'b0;
			end else if (edge_full) begin
				o_locked <= 1'b1;
			end
		end
	end
endmodule

// file: logic/uprc_top.sv
// Reference clock, PLL lock and start-up control of the transceiver.
// Assumes pins are asynchronous; i_low_power_enter comes from local logic.
// Functional notes
// - Two clocking modes: link-sourced 60MHz reference or device-generated clock.
// - At start-up, clock-out pin tied high selects link-sourced 60MHz mode.
// - Link-sourced mode: DIR falls only after PLL lock.
// - Device-sourced mode: after lock drive clock out and drop DIR.
// - Generated clock accurate within 500ppm of nominal.
// - No phase relation imposed between reference edges and interface signals.
// - Only rising reference edges matter.
// - PLL yields 480MHz bit clock for transmit and receive.
// - Late reference start delays interface start-up equally.
// - Running reference while reset pin low never starts the device.
// - STP assertion takes the device out of low power.
// - Reference loss drops lock; clock out falls to PLL minimum.
// - After reset drive idle, hold DIR until lock, check STP low.
// - DIR stays high while STP high; link drives idle after.
// - Reset pin low at least 1us resets all state except the clock-mode strap output.
`timescale 1ns/1ps
module uprc_top #(
	parameter logic [7:0] LOCK_EDGES = uprc_pkg::LOCK_EDGES,
	parameter logic [7:0] REF_TIMEOUT = uprc_pkg::REF_TIMEOUT_CYC
) (
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	input wire logic i_hardware_reset_n,
	input wire logic i_reference_clock_in,
	input wire logic i_interface_clock_out,
	input wire logic i_stp,
	input wire logic i_low_power_enter,
	output logic o_dir,
	output logic [7:0] o_data,
	output logic o_data_oe,
	output logic o_interface_clock_out,
	output logic o_interface_clock_out_oe,
	output logic o_link_sourced_clock_mode,
	output logic o_pll_locked,
	output logic o_bit_clock_run,
	output logic o_low_power
);
	uprc_pkg::uprc_state_t state;
	uprc_pkg::uprc_state_t next_state;
	logic rst_s1;
	logic rst_s2;
	logic sense_s1;
	logic sense_s2;
	logic stp_s1;
	logic stp_s2;
	logic [7:0] rst_cnt;
	logic in_reset;
	logic locked;
	logic [7:0] div_cnt;
	logic clk_run;

	// Device holds the bus in every state but reset and run
	function automatic logic owns_bus(input uprc_pkg::uprc_state_t s);
		return (s != uprc_pkg::UPRC_RUN) && (s != uprc_pkg::UPRC_RESET);
	endfunction

	// Strap has been sampled once the sequence is past reset and strap
	function automatic logic past_strap(input uprc_pkg::uprc_state_t s);
		return (s != uprc_pkg::UPRC_STRAP) && (s != uprc_pkg::UPRC_RESET);
	endfunction

	// Two-flop synchronisers on every pin
	always_ff @(posedge i_sys_clk) begin
		rst_s1 <= i_hardware_reset_n;
		rst_s2 <= rst_s1;
		sense_s1 <= i_interface_clock_out;
		sense_s2 <= sense_s1;
		stp_s1 <= i_stp;
		stp_s2 <= stp_s1;
	end

	// Reset pin must stay low the minimum time to take effect
	wire rst_full = (rst_cnt >= uprc_pkg::RST_MIN_CYC);
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			rst_cnt <= 8'h00;
			in_reset <= 1'b1;
		end else if (rst_s2) begin
			rst_cnt <= 8'h00;
			in_reset <= 1'b0;
		end else if (!rst_full) begin
			rst_cnt <= rst_cnt + 8'h01;
		end else begin
			in_reset <= 1'b1;
		end
	end

	// Lock monitor held in reset once the reset pin has stayed low the minimum time
	uprc_lock_mon #(
		.LOCK_EDGES(LOCK_EDGES),
		.TIMEOUT(REF_TIMEOUT)
	) u_lock (
		.i_sys_clk(i_sys_clk),
		.i_sys_rst(i_sys_rst),
		.i_hold(in_reset),
		.i_reference_clock_in(i_reference_clock_in),
		.o_locked(locked),
		.o_ref_edge()
	);

	// Start-up sequence
	always_comb begin
		next_state = state;
		unique case (state)
			uprc_pkg::UPRC_RESET: begin
				if (!in_reset) begin
					next_state = uprc_pkg::UPRC_STRAP;
				end
			end
			uprc_pkg::UPRC_STRAP: begin
				next_state = uprc_pkg::UPRC_WAIT_LOCK;
			end
			uprc_pkg::UPRC_WAIT_LOCK: begin
				if (locked) begin
					next_state = uprc_pkg::UPRC_WAIT_STP;
				end
			end
			uprc_pkg::UPRC_WAIT_STP: begin
				if (!locked) begin
					next_state = uprc_pkg::UPRC_WAIT_LOCK;
				end else if (!stp_s2) begin
					next_state = uprc_pkg::UPRC_RUN;
				end
			end
			uprc_pkg::UPRC_RUN: begin
				if (i_low_power_enter) begin
					next_state = uprc_pkg::UPRC_LOW_POWER;
				end
			end
			uprc_pkg::UPRC_LOW_POWER: begin
				if (stp_s2) begin
					next_state = uprc_pkg::UPRC_WAIT_LOCK;
				end
			end
		endcase
		// Reset pin overrides every state
		if (in_reset) begin
			next_state = uprc_pkg::UPRC_RESET;
		end
	end

	// State register
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			state <= uprc_pkg::UPRC_RESET;
		end else begin
			state <= next_state;
		end
	end

	// Mode strap caught once after release of reset
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			o_link_sourced_clock_mode <= 1'b0;
		end else if (state == uprc_pkg::UPRC_STRAP) begin
			o_link_sourced_clock_mode <= sense_s2;
		end
	end

	// Next-state decodes shared by the output registers
	wire lp_next = (next_state == uprc_pkg::UPRC_LOW_POWER);
	wire dir_next = owns_bus(next_state);
	wire lock_ok = locked && !in_reset;

	// DIR high until locked and STP low; idle driven while DIR high, except in low power
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			o_dir <= 1'b0;
			o_data <= uprc_pkg::ULPI_IDLE;
			o_data_oe <= 1'b0;
			o_low_power <= 1'b0;
			o_pll_locked <= 1'b0;
			o_bit_clock_run <= 1'b0;
		end else begin
			// Bus ownership follows the next state
			o_dir <= dir_next;
			o_data <= uprc_pkg::ULPI_IDLE;
			o_data_oe <= dir_next && !lp_next;
			o_low_power <= lp_next;
			o_pll_locked <= lock_ok;
			o_bit_clock_run <= lock_ok;
		end
	end

	// Device-sourced clock: free of reference phase, slows when unlocked
	wire phy_mode = !o_link_sourced_clock_mode;
	wire [7:0] half_div = locked ? uprc_pkg::INTERFACE_CLOCK_OUT_LOCK_DIV : uprc_pkg::INTERFACE_CLOCK_OUT_MIN_DIV;
	wire div_done = (div_cnt >= half_div - 8'h01);
	wire clk_gate = clk_run && phy_mode;
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst || in_reset) begin
			clk_run <= 1'b0;
			div_cnt <= 8'h00;
			o_interface_clock_out <= 1'b0;
			o_interface_clock_out_oe <= 1'b0;
		end else begin
			// Divider starts only once locked in device-sourced mode
			if (phy_mode && locked && past_strap(state)) begin
				clk_run <= 1'b1;
			end
			// Pin driven only while the divider runs
			o_interface_clock_out_oe <= clk_gate;
			if (clk_gate) begin
				if (div_done) begin
					div_cnt <= 8'h00;
					o_interface_clock_out <= ~o_interface_clock_out;
				end else begin
					div_cnt <= div_cnt + 8'h01;
				end
			end
		end
	end
endmodule

// file: testbench/uprc_link_model.sv
// Link-side model: gated reference clock and clock-out strap wiring.
// Assumes the bench chooses the strap and when the reference runs.
`timescale 1ns/1ps
module uprc_link_model (
	input wire logic i_ref_en,
	input wire logic i_strap_high,
	input wire logic i_clk_out,
	input wire logic i_clk_out_oe,
	output logic o_ref,
	output wire logic o_pin
);
	// Host link keeps resume autostart enabled in both clock modes
	localparam logic RESUME_AUTOSTART_ENABLE = 1'b1;
	initial begin
		o_ref = 1'b0;
		#13;
		forever #200 o_ref = i_ref_en ? !o_ref : 1'b0;
	end
	assign o_pin = i_strap_high ? 1'b1 : (i_clk_out_oe && i_clk_out);
endmodule

// file: testbench/uprc_top_sva.sv
// Checker for start-up, lock and DIR behaviour of uprc_top.
// Assumes the single system clock domain.
`timescale 1ns/1ps
module uprc_top_sva #(
	parameter logic [7:0] LOCK_EDGES = uprc_pkg::LOCK_EDGES,
	parameter logic [7:0] REF_TIMEOUT = uprc_pkg::REF_TIMEOUT_CYC
) (
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	input wire logic i_hardware_reset_n,
	input wire logic i_reference_clock_in,
	input wire logic i_stp,
	input wire logic o_dir,
	input wire logic [7:0] o_data,
	input wire logic o_interface_clock_out_oe,
	input wire logic o_link_sourced_clock_mode,
	input wire logic o_pll_locked
);
	logic ref_q;
	logic rise;
	logic [7:0] still;
	logic [7:0] rises;
	logic [7:0] low_cnt;
	assign rise = i_reference_clock_in && !ref_q;
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			ref_q <= 1'b0;
			still <= 8'h00;
			rises <= 8'h00;
			low_cnt <= 8'h00;
		end else begin
			ref_q <= i_reference_clock_in;
			still <= rise ? 8'h00 : still + {7'h00, still != 8'hff};
			rises <= i_hardware_reset_n ? rises + {7'h00, rise && rises != 8'hff} : 8'h00;
			low_cnt <= i_hardware_reset_n ? 8'h00 : low_cnt + {7'h00, low_cnt != 8'hff};
		end
	end
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_sys_rst);
	sequence stp_held;
		(o_dir && i_stp && i_hardware_reset_n) [*4];
	endsequence
	sequence dir_release;
		$fell(o_dir) && i_hardware_reset_n;
	endsequence
	bus_idle_a: assert property (o_data == uprc_pkg::ULPI_IDLE)
		else $error("bus not idle");
	dir_release_a: assert property (dir_release |-> o_pll_locked && !$past(i_stp))
		else $error("dir fell early");
	stp_hold_a: assert property (stp_held |=> o_dir)
		else $error("dir fell with stp high");
	clk_oe_mode_a: assert property (o_interface_clock_out_oe |-> !o_link_sourced_clock_mode)
		else $error("clock out driven in link mode");
	strap_hold_a: assert property (o_dir && $past(o_dir) && $past(o_dir, 2)
		|-> $stable(o_link_sourced_clock_mode))
		else $error("mode changed");
	lock_count_a: assert property ($rose(o_pll_locked) |-> rises >= LOCK_EDGES)
		else $error("lock too soon");
	ref_loss_a: assert property (still > REF_TIMEOUT + 8'h08 |-> !o_pll_locked)
		else $error("lock kept without reference");
	reset_pin_a: assert property (low_cnt >= 8'h1c |-> !o_dir && !o_pll_locked)
		else $error("active in reset");
endmodule
bind uprc_top uprc_top_sva #(.LOCK_EDGES(LOCK_EDGES), .REF_TIMEOUT(REF_TIMEOUT)) uprc_top_sva_i (.*);

// file: testbench/uprc_top_bench.sv
// Bench for uprc_top: both clock modes, late reference, STP hold, low power.
// Assumes the link model supplies reference clock and strap level.
`timescale 1ns/1ps
module uprc_top_bench;
	logic clk, rst, rst_n, ref_en, strap, stp, lp, ref_c, pin, dir, ck, ck_oe, mode, lock, lpo;
	logic doe, bcr;
	int errors, checks_done, cyc, seed, k;
	uprc_link_model uprc_link_model_i (.i_ref_en(ref_en), .i_strap_high(strap),
		.i_clk_out(ck), .i_clk_out_oe(ck_oe), .o_ref(ref_c), .o_pin(pin));
	uprc_top uprc_top_i (.i_sys_clk(clk), .i_sys_rst(rst), .i_hardware_reset_n(rst_n),
		.i_reference_clock_in(ref_c), .i_interface_clock_out(pin), .i_stp(stp),
		.i_low_power_enter(lp), .o_dir(dir), .o_data(), .o_data_oe(doe),
		.o_interface_clock_out(ck), .o_interface_clock_out_oe(ck_oe),
		.o_link_sourced_clock_mode(mode), .o_pll_locked(lock), .o_bit_clock_run(bcr),
		.o_low_power(lpo));
	initial begin
		clk = 1'b0;
		forever #25 clk = !clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 8000) begin
			errors++;
			test_done;
		end
	end
	function automatic logic exp_mode(input logic s);
		return s;
	endfunction
	function automatic int exp_half(input logic locked_exp);
		return locked_exp ? int'(uprc_pkg::INTERFACE_CLOCK_OUT_LOCK_DIV) : int'(uprc_pkg::INTERFACE_CLOCK_OUT_MIN_DIV);
	endfunction
	task automatic chk_num(input string name, input int exp, input int got);
		checks_done++;
		if (got != exp) begin
			errors++;
			$display("mismatch %s expected %0d seen %0d", name, exp, got);
		end
	endtask
	task automatic chk(input string name, input logic exp, input logic got);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %s expected %b seen %b", name, exp, got);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#5;
	endtask
	task automatic wait_dir_low;
		for (k = 0; k < 600 && dir !== 1'b0; k++) begin
			step(1);
		end
		chk("dir", 1'b0, dir);
	endtask
	task automatic chk_half(input logic locked_exp);
		logic prev;
		int n;
		n = 0;
		for (int p = 0; p < 2; p++) begin
			prev = ck;
			n = 0;
			while (ck === prev && n < 40) begin
				step(1);
				n++;
			end
		end
		chk_num("clock half period", exp_half(locked_exp), n);
	endtask
	task automatic test_done;
		$display("errors %0d checks %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic startup(input logic s, input int late);
		rst_n = 1'b0;
		ref_en = 1'b1;
		strap = s;
		stp = 1'b1;
		step(40);
		chk("dir", 1'b0, dir);
		rst_n = 1'b1;
		ref_en = (late == 0);
		step(late + 8);
		chk("dir", 1'b1, dir);
		chk("data oe", 1'b1, doe);
		chk("lock", 1'b0, lock);
		ref_en = 1'b1;
		step(200 + ($unsigned($random(seed)) % 64));
		chk("dir", 1'b1, dir);
		chk("lock", 1'b1, lock);
		chk("bit clock", 1'b1, bcr);
		stp = 1'b0;
		wait_dir_low;
		chk("data oe", 1'b0, doe);
		chk("mode", exp_mode(s), mode);
		step(3);
		chk("clock oe", !s, ck_oe);
		if (!s) begin
			chk_half(1'b1);
			ref_en = 1'b0;
			step(50);
			chk("lock", 1'b0, lock);
			chk_half(1'b0);
		end
		$display("startup done mode %b late %0d", s, late);
	endtask
	initial begin
		rst = 1'b1;
		rst_n = 1'b0;
		ref_en = 1'b0;
		strap = 1'b1;
		stp = 1'b1;
		lp = 1'b0;
		seed = 41;
		step(8);
		rst = 1'b0;
		for (int i = 0; i < 4; i++) begin
			startup(i[0], (i > 1) ? 60 : 0);
		end
		lp = 1'b1;
		step(1);
		lp = 1'b0;
		step(2);
		chk("low power", 1'b1, lpo);
		ref_en = 1'b0;
		step(50);
		chk("lock", 1'b0, lock);
		chk("bit clock", 1'b0, bcr);
		stp = 1'b1;
		ref_en = 1'b1;
		step(6);
		chk("low power", 1'b0, lpo);
		step(200);
		stp = 1'b0;
		wait_dir_low;
		$display("low power done");
		test_done;
	end
endmodule
